/* rtl/flash_host_pkg.sv */
`default_nettype none
package flash_host_pkg;

	// ---------------------------------------------------------------
	// Host register map (word index on the command port)
	// ---------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS    = 4'h0;
	localparam logic [3:0] ADDR_OFS    = 4'h1;
	localparam logic [3:0] WDATA_OFS   = 4'h2;
	localparam logic [3:0] STATUS_OFS  = 4'h3;
	localparam logic [3:0] RDATA_OFS   = 4'h4;
	localparam logic [3:0] HISTORY_OFS = 4'h5;

	// Command codes written to CTRL bits [2:0]
	localparam logic [2:0] CMD_WRITE     = 3'h1;
	localparam logic [2:0] CMD_READ      = 3'h2;
	localparam logic [2:0] CMD_PROTECT   = 3'h3;
	localparam logic [2:0] CMD_UNPROTECT = 3'h4;
	localparam logic [2:0] CMD_VERIFY    = 3'h5;

	// Status bit positions
	localparam int BUSY_BIT    = 0;
	localparam int WINDOW_BIT  = 1;
	localparam int PROT_BIT    = 2;
	localparam int TOGGLE_BIT  = 3;
	localparam int POLL_BIT    = 4;
	localparam int RISKY_BIT   = 5;

	// Device data and address bit positions
	localparam int POLLING_BIT_POS      = 7;
	localparam int TOGGLE_BIT_ONE_POS   = 6;
	localparam int ERASE_WINDOW_POS     = 3;
	localparam int PROTECT_STATUS_POS   = 0;
	localparam int PROTECT_SEL_POS      = 6;
	localparam int IDENT_SEL_POS        = 1;

	// ---------------------------------------------------------------
	// Timing, 20 MHz clock
	// ---------------------------------------------------------------
	localparam int CLOCK_HZ       = 20_000_000;
	localparam int CLOCK_NS       = 1_000_000_000 / CLOCK_HZ;
	localparam int STROBE_NS      = 45;
	localparam int STROBE_CYC     = (STROBE_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int ACCESS_NS      = 120;
	localparam int ACCESS_CYC     = (ACCESS_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int RECOVER_NS     = 20;
	localparam int RECOVER_CYC    = (RECOVER_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int VSETUP_US      = 4;
	localparam int VSETUP_CYC     = VSETUP_US * (CLOCK_HZ / 1_000_000);
	localparam int PROTECT_US     = 10;
	localparam int PROTECT_CYC    = PROTECT_US * (CLOCK_HZ / 1_000_000);
	localparam int UNPROTECT_MS   = 12;
	localparam int UNPROTECT_CYC  = UNPROTECT_MS * (CLOCK_HZ / 1_000);

	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Pins driven toward the flash
	typedef struct packed {
		logic        chipSelectN;
		logic        writeStrobeN;
		logic        outputGateN;
		logic        highVoltageAddr;
		logic        highVoltageGate;
		logic [18:0] address;
	} flash_pins_type;

	typedef enum logic [1:0] {
		HV_NONE,
		HV_PROTECT,
		HV_UNPROTECT,
		HV_VERIFY
	} hv_mode_type;

endpackage
`default_nettype wire

/* rtl/read_history_mem.sv */
`default_nettype none
module read_history_mem
	import flash_host_pkg::*;
#(
	parameter int DEPTH = 8
) (
	// Clock (no reset)
	input  wire logic                     clock,
	// Write side
	input  wire logic                     writeEn,
	input  wire logic [$clog2(DEPTH)-1:0] writeIdx,
	input  wire logic [7:0]               writeData,
	// Read side
	input  wire logic [$clog2(DEPTH)-1:0] readIdx,
	output logic      [7:0]               readData
);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("read_history_mem needs a power of two entries");
		end
	end

	logic [7:0] store [DEPTH];

	always_ff @(posedge clock) begin
		if (writeEn) begin
			store[writeIdx] <= writeData;
		end
		readData <= store[readIdx];
	end

endmodule
`default_nettype wire

/* rtl/flash_host_ctrl.sv */
// Function
// - Host reads flag before and after command
// - Write only with select, strobe low, gate high
// - Protect: high voltage, select-low, strobe pulse
// - Unprotect: high voltage, select-high, strobe pulse
`default_nettype none
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int HISTORY_DEPTH = 8,
	parameter int UNPROTECT_CYCLES = UNPROTECT_CYC
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 srst,
	// Command port
	input  wire logic [3:0]           regAddr,
	input  wire logic [31:0]          regWriteData,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	output logic      [31:0]          regReadData,
	// Flash pins
	output flash_pins_type            flashPins,
	input  wire logic [7:0]           dataIn,
	output logic      [7:0]           dataOut,
	output logic                      dataOutEnableN
);

	initial begin
		// History index wraps freely, so the depth must be a power of two
		if (HISTORY_DEPTH < 2 || (HISTORY_DEPTH & (HISTORY_DEPTH - 1)) != 0
			|| UNPROTECT_CYCLES < 1) begin
			$error("flash_host_ctrl parameters out of range");
		end
	end

	localparam int HW = $clog2(HISTORY_DEPTH);
	localparam int CW = $clog2(UNPROTECT_CYCLES + PROTECT_CYC + 1) + 1;

	typedef enum logic [2:0] {
		IDLE, SETUP, PULSE, RECOVER, HOLD
	} phase_type;

	// -------------------------------------------------------------
	// Input synchroniser
	// -------------------------------------------------------------
	logic [7:0] dataMeta_q, dataSync_q;
	always_ff @(posedge clock) begin
		dataMeta_q <= dataIn;
		dataSync_q <= dataMeta_q;
	end

	// -------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------
	phase_type      phase_q, phase_d;
	logic [2:0]     cmd_q, cmd_d;
	logic [CW-1:0]  count_q, count_d;
	logic [18:0]    addr_q, addr_d;
	logic [7:0]     wdata_q, wdata_d;
	logic [7:0]     rdata_q, rdata_d;
	logic [7:0]     before_q, before_d;
	logic           haveBefore_q, haveBefore_d;
	logic           risky_q, risky_d;
	logic           prot_q, prot_d;
	logic           toggleSeen_q, toggleSeen_d;
	logic           lastToggle_q, lastToggle_d;
	logic [HW-1:0]  hidx_q, hidx_d;
	flash_pins_type pins_q, pins_d;
	logic           drive_q, drive_d;
	logic           driveN_q, driveN_d;
	logic [31:0]    rd_q, rd_d;
	logic           histWrite;
	logic [7:0]     histData;
	logic           busy;

	assign busy = (phase_q != IDLE);

	always_comb begin
		phase_d      = phase_q;
		cmd_d        = cmd_q;
		count_d      = count_q;
		addr_d       = addr_q;
		wdata_d      = wdata_q;
		rdata_d      = rdata_q;
		before_d     = before_q;
		haveBefore_d = haveBefore_q;
		risky_d      = risky_q;
		prot_d       = prot_q;
		toggleSeen_d = toggleSeen_q;
		lastToggle_d = lastToggle_q;
		hidx_d       = hidx_q;
		pins_d       = pins_q;
		drive_d      = drive_q;
		histWrite    = 1'b0;
		rd_d         = 32'h0000_0000;
		if (regWrite && !busy) begin
			if (regAddr == ADDR_OFS) begin
				addr_d = regWriteData[18:0];
			end else if (regAddr == WDATA_OFS) begin
				wdata_d = regWriteData[7:0];
			end else if (regAddr == CTRL_OFS) begin
				cmd_d   = regWriteData[2:0];
				count_d = CW'(VSETUP_CYC);
				phase_d = SETUP;
				pins_d.address = addr_q;
				pins_d.chipSelectN = 1'b1;
				pins_d.writeStrobeN = 1'b1;
				pins_d.outputGateN = 1'b1;
				pins_d.highVoltageAddr = 1'b0;
				pins_d.highVoltageGate = 1'b0;
				if (regWriteData[2:0] == CMD_PROTECT) begin
					pins_d.address[PROTECT_SEL_POS] = 1'b0;
					pins_d.highVoltageAddr = 1'b1;
					pins_d.highVoltageGate = 1'b1;
				end else if (regWriteData[2:0] == CMD_UNPROTECT) begin
					pins_d.address[PROTECT_SEL_POS] = 1'b1;
					pins_d.highVoltageAddr = 1'b1;
					pins_d.highVoltageGate = 1'b1;
				end else if (regWriteData[2:0] == CMD_VERIFY) begin
					pins_d.address[IDENT_SEL_POS] = 1'b1;
					pins_d.highVoltageAddr = 1'b1;
				end else begin
					// Plain bus cycles need no high voltage settle time
					count_d = CW'(1);
				end
				if (regWriteData[2:0] != CMD_WRITE && regWriteData[2:0] != CMD_READ
					&& regWriteData[2:0] != CMD_PROTECT
					&& regWriteData[2:0] != CMD_UNPROTECT
					&& regWriteData[2:0] != CMD_VERIFY) begin
					phase_d = IDLE;
				end
			end
		end
		if (regRead) begin
			if (regAddr == STATUS_OFS) begin
				rd_d[BUSY_BIT]   = busy;
				rd_d[WINDOW_BIT] = rdata_q[ERASE_WINDOW_POS];
				rd_d[PROT_BIT]   = prot_q;
				rd_d[TOGGLE_BIT] = toggleSeen_q;
				rd_d[POLL_BIT]   = rdata_q[POLLING_BIT_POS];
				rd_d[RISKY_BIT]  = risky_q;
			end else if (regAddr == RDATA_OFS) begin
				rd_d[7:0] = rdata_q;
			end else if (regAddr == ADDR_OFS) begin
				rd_d[18:0] = addr_q;
			end else if (regAddr == WDATA_OFS) begin
				rd_d[7:0] = wdata_q;
			end else if (regAddr == HISTORY_OFS) begin
				rd_d[7:0] = histData;
			end
		end
		// Clear sits before the capture below, so a fresh 0-to-1 still wins
		if (regWrite && regAddr == STATUS_OFS && regWriteData[RISKY_BIT]) begin
			risky_d = 1'b0;
		end
		case (phase_q)
			IDLE: begin
			end
			SETUP: begin
				if (count_q > CW'(1)) begin
					count_d = count_q - CW'(1);
				end else begin
					phase_d = PULSE;
					pins_d.chipSelectN = 1'b0;
					// write: gate high, select and strobe low
					if (cmd_q == CMD_WRITE || cmd_q == CMD_PROTECT
						|| cmd_q == CMD_UNPROTECT) begin
						pins_d.writeStrobeN = 1'b0;
						drive_d = (cmd_q == CMD_WRITE);
						count_d = (cmd_q == CMD_WRITE) ? CW'(STROBE_CYC)
							: (cmd_q == CMD_PROTECT) ? CW'(PROTECT_CYC)
							: CW'(UNPROTECT_CYCLES);
					end else begin
						pins_d.outputGateN = 1'b0;
						count_d = CW'(ACCESS_CYC);
					end
				end
			end
			PULSE: begin
				if (count_q > CW'(1)) begin
					count_d = count_q - CW'(1);
				end else begin
					phase_d = RECOVER;
					count_d = CW'(RECOVER_CYC);
					pins_d.writeStrobeN = 1'b1;
					pins_d.outputGateN = 1'b1;
					pins_d.chipSelectN = 1'b1;
					if (cmd_q == CMD_READ || cmd_q == CMD_VERIFY) begin
						rdata_d = dataSync_q;
						histWrite = 1'b1;
						hidx_d = hidx_q + HW'(1);
						toggleSeen_d = (dataSync_q[TOGGLE_BIT_ONE_POS] != lastToggle_q);
						lastToggle_d = dataSync_q[TOGGLE_BIT_ONE_POS];
						if (cmd_q == CMD_VERIFY || addr_q[IDENT_SEL_POS]) begin
							prot_d = dataSync_q[PROTECT_STATUS_POS];
						end
						if (haveBefore_q && dataSync_q[ERASE_WINDOW_POS]
							&& !before_q[ERASE_WINDOW_POS]) begin
							risky_d = 1'b1;
						end
						before_d = dataSync_q;
						haveBefore_d = 1'b1;
					end
				end
			end
			RECOVER: begin
				drive_d = 1'b0;
				pins_d.highVoltageAddr = 1'b0;
				pins_d.highVoltageGate = 1'b0;
				if (count_q > CW'(1)) begin
					count_d = count_q - CW'(1);
				end else begin
					phase_d = HOLD;
				end
			end
			HOLD: begin
				phase_d = IDLE;
			end
			default: begin
				phase_d = IDLE;
			end
		endcase
		driveN_d = ~drive_d;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			phase_q      <= IDLE;
			cmd_q        <= 3'h0;
			count_q      <= '0;
			addr_q       <= '0;
			wdata_q      <= RESET_BYTE;
			rdata_q      <= RESET_BYTE;
			before_q     <= RESET_BYTE;
			haveBefore_q <= 1'b0;
			risky_q      <= 1'b0;
			prot_q       <= 1'b0;
			toggleSeen_q <= 1'b0;
			lastToggle_q <= 1'b0;
			hidx_q       <= '0;
			pins_q       <= '{chipSelectN: 1'b1, writeStrobeN: 1'b1, outputGateN: 1'b1,
				highVoltageAddr: 1'b0, highVoltageGate: 1'b0, address: 19'h0};
			drive_q      <= 1'b0;
			driveN_q     <= 1'b1;
			rd_q         <= 32'h0000_0000;
		end else begin
			phase_q      <= phase_d;
			cmd_q        <= cmd_d;
			count_q      <= count_d;
			addr_q       <= addr_d;
			wdata_q      <= wdata_d;
			rdata_q      <= rdata_d;
			before_q     <= before_d;
			haveBefore_q <= haveBefore_d;
			risky_q      <= risky_d;
			prot_q       <= prot_d;
			toggleSeen_q <= toggleSeen_d;
			lastToggle_q <= lastToggle_d;
			hidx_q       <= hidx_d;
			pins_q       <= pins_d;
			drive_q      <= drive_d;
			driveN_q     <= driveN_d;
			rd_q         <= rd_d;
		end
	end

	read_history_mem #(
		.DEPTH (HISTORY_DEPTH)
	) history (
		.clock     (clock),
		.writeEn   (histWrite),
		.writeIdx  (hidx_q),
		.writeData (dataSync_q),
		.readIdx   (hidx_q - HW'(1)),
		.readData  (histData)
	);

	assign flashPins      = pins_q;
	assign dataOut        = wdata_q;
	assign dataOutEnableN = driveN_q;
	assign regReadData    = rd_q;

endmodule
`default_nettype wire

/* tb/flash_host_ctrl_properties.sv */
`default_nettype none
module flash_host_ctrl_properties
	import flash_host_pkg::*;
(
	// Clock and reset
	input wire logic           clock,
	input wire logic           srst,
	// Command port
	input wire logic           regRead,
	input wire logic [31:0]    regReadData,
	// Flash pins
	input wire flash_pins_type flashPins,
	input wire logic           dataOutEnableN
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic csN = flashPins.chipSelectN;
	wire logic weN = flashPins.writeStrobeN;
	wire logic oeN = flashPins.outputGateN;
	wire logic hvG = flashPins.highVoltageGate;
	wire logic hvA = flashPins.highVoltageAddr;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence plainStart;
		$fell(weN) && !hvG;
	endsequence
	sequence hvStart;
		$fell(weN) && hvG;
	endsequence
	a_idle_after_reset: assert property (
		$fell(srst) |-> csN && weN && dataOutEnableN && !hvG && !hvA)
		else $error("pins not idle after reset");
	a_write_qualified: assert property (
		!weN && !hvG |-> oeN && !csN) else $error("strobe without select or gate low");
	a_write_pulse_one: assert property (
		plainStart |=> weN) else $error("plain write strobe not one cycle");
	a_no_bus_fight: assert property (
		!dataOutEnableN && !hvG |-> oeN) else $error("data driven while gate low");
	a_hv_strobe_pins: assert property (
		!weN && hvG |-> hvA && !csN) else $error("protect strobe with wrong pins");
	a_hv_setup_time: assert property (
		$rose(hvG) |-> weN [*8]) else $error("strobe too soon after high voltage");
	a_hv_pulse_long: assert property (
		hvStart |-> !weN [*8]) else $error("protect strobe too short");
	a_verify_pins: assert property (
		hvA && !hvG && !oeN |-> flashPins.address[IDENT_SEL_POS] && weN && !csN)
		else $error("verify read with wrong pins");
	a_read_data_slot: assert property (
		!regRead |=> regReadData == 32'h0) else $error("read data outside its slot");
endmodule
`default_nettype wire

/* tb/flash_device_model.sv */
`default_nettype none
module flash_device_model
	import flash_host_pkg::*;
#(
	parameter int         WINDOW_CYC = 60,
	parameter int         ERASE_CYC  = 100,
	// Arbitrary identification byte
	parameter logic [7:0] IDENT_CODE = 8'hc3
) (
	// Clock
	input  wire logic           clock,
	// Host side
	input  wire flash_pins_type pins,
	input  wire logic [7:0]     busIn,
	input  wire logic           busEnN,
	output logic      [7:0]     busOut
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        erasing = 1'b0;
	logic        prot    = 1'b0;
	logic        tog     = 1'b0;
	logic        oeQ     = 1'b1;
	int          timer   = 0;
	logic [7:0]  mem     = 8'hff;
	logic [18:0] memAddr = 19'h0;
	logic [7:0]  lastOut = 8'h00;
	logic [7:0]  val;
	logic        drv, wrOn, win;
	assign win = timer >= WINDOW_CYC;
	assign wrOn = !pins.writeStrobeN && !pins.chipSelectN;
	assign drv = !pins.chipSelectN && !pins.outputGateN;
	always_comb begin
		if (pins.highVoltageAddr) begin
			val = pins.address[IDENT_SEL_POS] ? {7'h0, prot} : IDENT_CODE;
		end else if (erasing) begin
			val = {1'b0, tog, 2'b0, win, 3'b0};
		end else begin
			val = (pins.address == memAddr) ? mem : 8'hff;
		end
	end
	// No pull-up, so a released bus must not echo the last byte
	assign busOut = drv ? val : ~lastOut;
	always @(posedge clock) begin
		oeQ <= pins.outputGateN;
		if (drv) lastOut <= val;
		if (erasing) timer <= timer + 1;
		if (timer == WINDOW_CYC + ERASE_CYC) begin
			erasing <= 1'b0;
			timer <= 0;
		end
		if (erasing && drv && oeQ) tog <= !tog;
		if (wrOn && pins.highVoltageGate && pins.highVoltageAddr) begin
			prot <= !pins.address[PROTECT_SEL_POS];
		end else if (wrOn && pins.outputGateN && !busEnN && !win) begin
			if (busIn == 8'h30) erasing <= 1'b1;
			else if (!erasing) begin
				mem <= busIn;
				memAddr <= pins.address;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/flash_host_ctrl_tb_top.sv */
`default_nettype none
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin nMismatch++; \
	$display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module flash_host_ctrl_tb_top
	import flash_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic           clock = 1'b0;
	logic           srst = 1'b1;
	logic [3:0]     regAddr = 4'h0;
	logic [31:0]    regWriteData = 32'h0;
	logic           regWrite = 1'b0;
	logic           regRead = 1'b0;
	logic [31:0]    regReadData;
	flash_pins_type flashPins;
	logic [7:0]     dataIn;
	logic [7:0]     dataOut;
	logic           dataOutEnableN;
	logic [31:0]    s;
	int             nMismatch = 0;
	int             testsRun = 0;

	always #25 clock = ~clock;

	// Short unprotect pulse keeps the run brief
	flash_host_ctrl #(.UNPROTECT_CYCLES(50)) i_dut (.clock, .srst, .regAddr, .regWriteData,
		.regWrite, .regRead, .regReadData, .flashPins, .dataIn, .dataOut, .dataOutEnableN);
	flash_device_model #(.WINDOW_CYC(60), .ERASE_CYC(100)) i_flash (.clock,
		.pins(flashPins), .busIn(dataOut), .busEnN(dataOutEnableN), .busOut(dataIn));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic stopTest();
		$display("compares %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regReadData;
	endtask
	// Busy is polled with a bound so a hung sequencer ends the run
	task automatic cmd(input logic [2:0] c, input logic [18:0] a, input logic [7:0] d);
		wr(ADDR_OFS, {13'h0, a});
		wr(WDATA_OFS, {24'h0, d});
		wr(CTRL_OFS, {29'h0, c});
		for (int i = 0; i < 3000; i++) begin
			rd(STATUS_OFS, s);
			if (s[BUSY_BIT] === 1'b0) return;
		end
		nMismatch++;
		stopTest();
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		rd(STATUS_OFS, s);
		`CHK(s, 32'h0)
		rd(4'hf, s);
		`CHK(s, 32'h0)
		// An undefined command code must leave the sequencer idle
		wr(CTRL_OFS, 32'h7);
		rd(STATUS_OFS, s);
		`CHK(s, 32'h0)
		$display("reset test done");
		cmd(CMD_WRITE, 19'h01234, 8'h5c);
		rd(ADDR_OFS, s);
		`CHK(s, 32'h0000_1234)
		rd(WDATA_OFS, s);
		`CHK(s, 32'h0000_005c)
		cmd(CMD_READ, 19'h01234, 8'h00);
		rd(RDATA_OFS, s);
		`CHK(s[7:0], 8'h5c)
		rd(HISTORY_OFS, s);
		`CHK(s[7:0], 8'h5c)
		$display("write test done");
		for (int k = 0; k < 2; k++) begin
			cmd(k ? CMD_UNPROTECT : CMD_PROTECT, 19'h0, 8'h00);
			// Ident-select low here: only that bit may matter
			cmd(CMD_VERIFY, 19'h7fff9, 8'h00);
			rd(RDATA_OFS, s);
			`CHK(s[7:0], k ? 8'h00 : 8'h01)
			rd(STATUS_OFS, s);
			`CHK(s[PROT_BIT], k ? 1'b0 : 1'b1)
		end
		$display("protect test done");
		cmd(CMD_WRITE, 19'h0, 8'h30);
		cmd(CMD_READ, 19'h0, 8'h00);
		rd(STATUS_OFS, s);
		`CHK(s & 32'h12, 32'h0)
		cmd(CMD_READ, 19'h0, 8'h00);
		rd(STATUS_OFS, s);
		`CHK(s & 32'h1a, 32'h08)
		repeat (60) @(posedge clock);
		#1;
		cmd(CMD_READ, 19'h0, 8'h00);
		rd(STATUS_OFS, s);
		`CHK(s & 32'h3a, 32'h2a)
		wr(STATUS_OFS, 32'h20);
		rd(STATUS_OFS, s);
		`CHK(s[RISKY_BIT], 1'b0)
		repeat (100) @(posedge clock);
		#1;
		cmd(CMD_READ, 19'h0, 8'h00);
		rd(RDATA_OFS, s);
		`CHK(s[7:0], 8'hff)
		rd(STATUS_OFS, s);
		`CHK(s & 32'h11, 32'h10)
		$display("erase test done");
		// Mid-run reset must bring pins and status back to idle
		@(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		rd(STATUS_OFS, s);
		`CHK(s, 32'h0)
		$display("second reset test done");
		stopTest();
	end
endmodule
bind flash_host_ctrl flash_host_ctrl_properties i_props (.clock, .srst, .regRead,
	.regReadData, .flashPins, .dataOutEnableN);
`default_nettype wire
